// ==== itpe_pkg.sv ====
// ------------------------------------------------------------
// Shared constants for the interval timer and pin edge block
// ------------------------------------------------------------
package itpe_pkg;
  // Bus geometry, pin count and compare width
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_PINS = 8;
  localparam int CMP_W = 12;
  // Register byte offsets, one aligned word each
  localparam logic [7:0] OFS_RISE_EN = 8'h00;
  localparam logic [7:0] OFS_FALL_EN = 8'h04;
  localparam logic [7:0] OFS_PCLK_EN = 8'h08;
  localparam logic [7:0] OFS_FLAGS_HI = 8'h0C;
  localparam logic [7:0] OFS_MASKS_HI = 8'h10;
  localparam logic [7:0] OFS_TMR_CTRL = 8'h14;
  localparam logic [7:0] OFS_FLAGS_LO = 8'h18;
  localparam logic [7:0] OFS_MASKS_LO = 8'h1C;
  localparam logic [7:0] OFS_OSC_SEL = 8'h20;
  localparam logic [7:0] OFS_COUNT = 8'h24;
  // Field positions
  localparam int BIT_CLK_SUPPLY = 7;
  localparam int BIT_TIMER_IRQ = 1;
  localparam int BIT_PIN0_IRQ = 2;
  localparam int BIT_OSC_SEL = 4;
  // Writable bits of the clock enable register
  localparam logic [7:0] PCLK_EN_MASK = 8'hA1;
  // Values after reset
  localparam logic [7:0] RST_EDGE = 8'h00;
  localparam logic [7:0] RST_PCLK_EN = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_MASKS = 8'hFF;
  localparam logic [15:0] RST_TMR_CTRL = 16'h0FFF;
  localparam logic [7:0] RST_OSC_SEL = 8'h00;
  // Timer control word layout
  typedef struct packed {
    logic run;
    logic [2:0] rsvd;
    logic [11:0] cmp;
  } itpe_tmr_ctrl_t;
endpackage : itpe_pkg

// ==== itpe_top.sv ====
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Rise/fall enable pair picks detected edges
// - Rise and fall enable registers, bit per pin
// - Clock supply bit 7 gates timer clock
// - Flag reads one while request pending
// - Mask zero allows, one blocks servicing
// - Timer flag and mask at bit 1
// - Pin zero flag and mask at bit 2
// - Run bit 15 counts; clear stops, zeroes
// - Period is compare plus one; never zero
// - Osc select one picks low-speed oscillator
module itpe_top (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [itpe_pkg::ADDR_W-1:0] PADDR,
  input wire logic [itpe_pkg::DATA_W-1:0] PWDATA,
  output logic [itpe_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic LOSC_CLK_IN,
  input wire logic [itpe_pkg::NUM_PINS-1:0] EXT_IRQ_PIN,
  output logic [itpe_pkg::NUM_PINS-1:0] PIN_EDGE,
  output logic TIMER_TICK,
  output logic TIMER_IRQ,
  output logic PIN0_IRQ
);
  import itpe_pkg::*;

  // ----------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------
  logic osc_s1, osc_s2, osc_s3; // Oscillator level chain
  logic [NUM_PINS-1:0] pin_s1, pin_s2, pin_s3; // Pin chains

  // Two flops before use; third flop only for edge compare
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      osc_s1 <= LOSC_CLK_IN;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      pin_s1 <= EXT_IRQ_PIN;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // ----------------------------------------------------------
  // Register state
  // ----------------------------------------------------------
  logic [7:0] rise_en, fall_en, pclk_en, osc_sel; // Config
  logic [7:0] if_hi, mk_hi, if_lo, mk_lo; // Flags, masks
  itpe_tmr_ctrl_t tmr_ctrl; // Timer control word
  logic [CMP_W-1:0] count; // Timer count
  logic [7:0] next_rise_en, next_fall_en, next_pclk_en;
  logic [7:0] next_osc_sel, next_if_hi, next_mk_hi;
  logic [7:0] next_if_lo, next_mk_lo;
  itpe_tmr_ctrl_t next_tmr_ctrl;
  logic [CMP_W-1:0] next_count;
  logic [NUM_PINS-1:0] edge_hit; // Qualified edges this cycle
  logic osc_tick; // One count clock period has passed
  logic match; // Count meets compare on a tick
  logic wr_en, rd_en; // Write strobe in access phase, read strobe in setup phase
  logic addr_ok; // Address hits a register
  logic [DATA_W-1:0] rd_word; // Read mux result
  logic [DATA_W-1:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [NUM_PINS-1:0] next_pin_edge;
  logic next_tick, next_timer_irq, next_pin0_irq;

  // ----------------------------------------------------------
  // Edge detection per pin
  // ----------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      // 00 off, 01 fall, 10 rise, 11 both
      assign edge_hit[gi] =
        (rise_en[gi] & pin_s2[gi] & ~pin_s3[gi]) |
        (fall_en[gi] & ~pin_s2[gi] & pin_s3[gi]);
    end
  endgenerate

  // ----------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------
  // Write strobe only in the access phase we answered; read strobe in the setup phase
  assign wr_en = PSEL & PENABLE & PREADY & PWRITE;
  assign rd_en = PSEL & ~PENABLE & ~PWRITE;

  // Read mux; reserved and unmapped bits read zero
  always_comb begin
    rd_word = '0;
    addr_ok = 1'b1;
    case (PADDR)
      OFS_RISE_EN: rd_word[7:0] = rise_en;
      OFS_FALL_EN: rd_word[7:0] = fall_en;
      OFS_PCLK_EN: rd_word[7:0] = pclk_en;
      OFS_FLAGS_HI: rd_word[7:0] = if_hi;
      OFS_MASKS_HI: rd_word[7:0] = mk_hi;
      OFS_TMR_CTRL: rd_word[15:0] = tmr_ctrl;
      OFS_FLAGS_LO: rd_word[7:0] = if_lo;
      OFS_MASKS_LO: rd_word[7:0] = mk_lo;
      OFS_OSC_SEL: rd_word[7:0] = osc_sel;
      OFS_COUNT: rd_word[CMP_W-1:0] = count;
      default: addr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------
  always_comb begin
    next_rise_en = rise_en;
    next_fall_en = fall_en;
    next_pclk_en = pclk_en;
    next_osc_sel = osc_sel;
    next_mk_hi = mk_hi;
    next_mk_lo = mk_lo;
    next_tmr_ctrl = tmr_ctrl;
    next_if_hi = if_hi;
    next_if_lo = if_lo;
    if (wr_en) begin
      case (PADDR)
        OFS_RISE_EN: next_rise_en = PWDATA[7:0];
        OFS_FALL_EN: next_fall_en = PWDATA[7:0];
        OFS_PCLK_EN: next_pclk_en = PWDATA[7:0] & PCLK_EN_MASK;
        OFS_FLAGS_HI: next_if_hi = PWDATA[7:0];
        OFS_MASKS_HI: next_mk_hi = PWDATA[7:0];
        OFS_TMR_CTRL: begin
          // Reserved bits 14..12 hold zero
          next_tmr_ctrl = PWDATA[15:0];
          next_tmr_ctrl.rsvd = 3'b000;
        end
        OFS_FLAGS_LO: next_if_lo = PWDATA[7:0];
        OFS_MASKS_LO: next_mk_lo = PWDATA[7:0];
        OFS_OSC_SEL: next_osc_sel = PWDATA[7:0] & 8'h10;
        default: next_osc_sel = osc_sel;
      endcase
    end
    // Hardware sets win over a same-cycle software clear
    next_if_hi[BIT_TIMER_IRQ] = next_if_hi[BIT_TIMER_IRQ] | match;
    // Pins 0..5 report at bits 2..7 of the low flag register
    next_if_lo[7:2] = next_if_lo[7:2] | edge_hit[5:0];
  end

  // ----------------------------------------------------------
  // Interval timer
  // ----------------------------------------------------------
  // Tick needs supply gate and oscillator select
  assign osc_tick = pclk_en[BIT_CLK_SUPPLY] & osc_sel[BIT_OSC_SEL] &
                    osc_s2 & ~osc_s3;
  // Compare zero is not blocked, so with compare zero a match at
  // count zero happens on every tick, the first one included
  assign match = tmr_ctrl.run & osc_tick & (count == tmr_ctrl.cmp);

  // Count, restart on match, clear when stopped
  always_comb begin
    next_count = count;
    if (!tmr_ctrl.run) begin
      next_count = '0;
    end else if (match) begin
      next_count = '0;
    end else if (osc_tick) begin
      next_count = count + 1'b1;
    end
  end

  // ----------------------------------------------------------
  // Output next values
  // ----------------------------------------------------------
  always_comb begin
    // Zero-wait answer in the first access cycle
    next_pready = PSEL & ~PENABLE;
    next_pslverr = PSEL & ~PENABLE & ~addr_ok;
    next_prdata = rd_en ? rd_word : '0;
    next_pin_edge = edge_hit;
    next_tick = match;
    // Mask zero lets the pending request through
    next_timer_irq = next_if_hi[BIT_TIMER_IRQ] &
                     ~next_mk_hi[BIT_TIMER_IRQ];
    next_pin0_irq = next_if_lo[BIT_PIN0_IRQ] &
                    ~next_mk_lo[BIT_PIN0_IRQ];
  end

  // ----------------------------------------------------------
  // State registers
  // ----------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rise_en <= RST_EDGE;
      fall_en <= RST_EDGE;
      pclk_en <= RST_PCLK_EN;
      osc_sel <= RST_OSC_SEL;
      if_hi <= RST_FLAGS;
      mk_hi <= RST_MASKS;
      if_lo <= RST_FLAGS;
      mk_lo <= RST_MASKS;
      tmr_ctrl <= RST_TMR_CTRL;
      count <= '0;
      PRDATA <= '0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PIN_EDGE <= '0;
      TIMER_TICK <= 1'b0;
      TIMER_IRQ <= 1'b0;
      PIN0_IRQ <= 1'b0;
    end else begin
      rise_en <= next_rise_en;
      fall_en <= next_fall_en;
      pclk_en <= next_pclk_en;
      osc_sel <= next_osc_sel;
      if_hi <= next_if_hi;
      mk_hi <= next_mk_hi;
      if_lo <= next_if_lo;
      mk_lo <= next_mk_lo;
      tmr_ctrl <= next_tmr_ctrl;
      count <= next_count;
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
      PIN_EDGE <= next_pin_edge;
      TIMER_TICK <= next_tick;
      TIMER_IRQ <= next_timer_irq;
      PIN0_IRQ <= next_pin0_irq;
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  AST_EDGE_CAUSE: assert property (
    PIN_EDGE[0] |-> $past((rise_en[0] & pin_s2[0] & ~pin_s3[0]) |
                          (fall_en[0] & ~pin_s2[0] & pin_s3[0])))
    else $error("pin edge without enabled edge");
  AST_RISE_WRITE: assert property (
    (wr_en && PADDR == OFS_RISE_EN) |=> rise_en == $past(PWDATA[7:0]))
    else $error("rise enable write lost");
  AST_SUPPLY_GATE: assert property (
    (!pclk_en[BIT_CLK_SUPPLY] && tmr_ctrl.run) |=> $stable(count))
    else $error("timer counted with supply stopped");
  AST_FLAG_PEND: assert property (
    PIN_EDGE[0] |-> if_lo[BIT_PIN0_IRQ])
    else $error("pin zero flag not pending");
  AST_MASK_BLOCK: assert property (
    mk_hi[BIT_TIMER_IRQ] |-> !TIMER_IRQ)
    else $error("masked timer request passed");
  AST_TIMER_BIT: assert property (
    TIMER_TICK |-> if_hi[BIT_TIMER_IRQ])
    else $error("timer flag not at bit one");
  AST_PIN0_IRQ: assert property (
    (if_lo[BIT_PIN0_IRQ] && !mk_lo[BIT_PIN0_IRQ]) |-> PIN0_IRQ)
    else $error("pin zero request not raised");
  AST_STOP_CLEAR: assert property (
    !tmr_ctrl.run |=> count == '0)
    else $error("count not cleared while stopped");
  AST_PERIOD: assert property (
    TIMER_TICK |-> $past(count) == $past(tmr_ctrl.cmp))
    else $error("tick not at compare value");
  AST_OSC_SEL: assert property (
    (!osc_sel[BIT_OSC_SEL] && tmr_ctrl.run) |=> $stable(count))
    else $error("timer counted without oscillator");
  AST_RESTART: assert property (
    TIMER_TICK |-> count == '0)
    else $error("count did not restart");

  COV_TICK: cover property (TIMER_TICK);
  COV_PIN_IRQ: cover property (PIN_EDGE[0] ##1 PIN0_IRQ);
  COV_READ: cover property (PSEL && PENABLE && PREADY && !PWRITE);
endmodule : itpe_top
`default_nettype wire

// ==== itpe_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// Far side: external pins and slow oscillator
// ------------------------------------------
module itpe_pin_model #(parameter int HALF = 8) (
  input wire logic clk,
  input wire logic [7:0] pin_set,
  output logic [7:0] pins,
  output logic losc
);
  int cnt; // Half period counter
  // Pins follow the request one edge late, like a slow board
  // Oscillator runs free; it never waits for software
  initial begin
    pins = 8'h00;
    losc = 1'b0;
    cnt = 0;
  end
  always @(posedge clk) begin
    pins <= pin_set;
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) losc <= ~losc;
  end
endmodule : itpe_pin_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// Bench for the timer and pin edge block
// ------------------------------------------
module testbench;
  import itpe_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, losc, tick, tirq, pirq;
  logic [7:0] paddr, pin_set, pins, pedge;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, osc_d;
  logic [7:0] seen_edges; // Every pin that pulsed since last clear
  logic [32:0] exp_q[$]; // Error bit and read data per transfer
  int mismatches, n_tests, edges, rises, last_per, nticks, n;
  itpe_top i_dut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LOSC_CLK_IN(losc), .EXT_IRQ_PIN(pins), .PIN_EDGE(pedge),
    .TIMER_TICK(tick), .TIMER_IRQ(tirq), .PIN0_IRQ(pirq));
  itpe_pin_model i_pins (.clk(clk), .pin_set(pin_set), .pins(pins),
    .losc(losc));
  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    n_tests++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic end_of_test;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // One APB transfer; holds the request until pready is seen
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] e, input logic err);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back({err, e});
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0000_0000, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000, e, 1'b0);
  endtask : rd
  // No tick may appear for a while
  task automatic quiet;
    n = nticks;
    repeat (300) @(posedge clk);
    chk(nticks, n);
  endtask : quiet
  // Answer watcher: oldest note against each completed transfer
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front());
  end
  // Pulse, oscillator and tick bookkeeping
  always @(posedge clk) begin
    osc_d <= losc;
    if (pedge[0] === 1'b1) edges++;
    seen_edges = seen_edges | pedge;
    if (losc && !osc_d) rises++;
    if (tick === 1'b1) begin
      last_per = rises;
      rises = 0;
      nticks++;
    end
  end
  // Watchdog, well beyond the expected run
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end
  initial begin
    static logic [7:0] ofs[10] = '{OFS_RISE_EN, OFS_FALL_EN, OFS_PCLK_EN,
      OFS_FLAGS_HI, OFS_MASKS_HI, OFS_TMR_CTRL, OFS_FLAGS_LO, OFS_MASKS_LO,
      OFS_OSC_SEL, OFS_COUNT};
    static logic [15:0] rv[10] = '{RST_EDGE, RST_EDGE, RST_PCLK_EN,
      RST_FLAGS, RST_MASKS, RST_TMR_CTRL, RST_FLAGS, RST_MASKS,
      RST_OSC_SEL, 0};
    logic [7:0] r;
    {arst_n, psel, penable, pwrite, paddr, pwdata, pin_set} = '0;
    {mismatches, n_tests, edges, rises, last_per, nticks} = '0;
    osc_d = 1'b0;
    seen_edges = 8'h00;
    void'($urandom(45));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 10; i++) rd(ofs[i], {16'h0000, rv[i]});
    xfer(1'b0, 8'h28, 0, 0, 1'b1);
    xfer(1'b1, 8'h28, 32'hFFFF_FFFF, 0, 1'b1);
    r = 8'($urandom());
    wr(OFS_RISE_EN, r);
    rd(OFS_RISE_EN, {24'h00_0000, r});
    wr(OFS_PCLK_EN, 32'hFFFF_FFFF);
    rd(OFS_PCLK_EN, {24'h00_0000, PCLK_EN_MASK});
    wr(OFS_TMR_CTRL, 32'h0000_FFFF);
    rd(OFS_TMR_CTRL, 32'h0000_8FFF);
    wr(OFS_TMR_CTRL, 32'h0000_0002);
    wr(OFS_MASKS_LO, 32'h0000_00FB);
    // Every edge mode on pin zero, one high pulse each
    for (int m = 0; m < 4; m++) begin
      wr(OFS_RISE_EN, {31'h0, m[1]});
      wr(OFS_FALL_EN, {31'h0, m[0]});
      wr(OFS_FLAGS_LO, 32'h0000_0000);
      edges = 0;
      pin_set <= 8'h01;
      repeat (10) @(posedge clk);
      pin_set <= 8'h00;
      repeat (10) @(posedge clk);
      chk(edges, m[1] + m[0]);
      chk(pirq, m != 0);
      rd(OFS_FLAGS_LO, (m != 0) ? 32'h0000_0004 : 0);
    end
    wr(OFS_MASKS_LO, 32'h0000_00FF);
    repeat (3) @(posedge clk);
    chk(pirq, 1'b0);
    // Rising edges on pins 1..7; pins 1..5 flag at bits 3..7
    wr(OFS_RISE_EN, 32'h0000_00FF);
    wr(OFS_FALL_EN, 32'h0000_0000);
    wr(OFS_FLAGS_LO, 32'h0000_0000);
    seen_edges = 8'h00;
    pin_set <= 8'hFE;
    repeat (10) @(posedge clk);
    pin_set <= 8'h00;
    repeat (10) @(posedge clk);
    chk(seen_edges, 8'hFE);
    rd(OFS_FLAGS_LO, 32'h0000_00F8);
    // Timer: supply, select, flag, mask, then compare and run in one write
    wr(OFS_PCLK_EN, 32'h0000_0080);
    wr(OFS_OSC_SEL, 32'h0000_0010);
    wr(OFS_FLAGS_HI, 32'h0000_0000);
    wr(OFS_MASKS_HI, 32'h0000_00FD);
    wr(OFS_TMR_CTRL, 32'h0000_8002);
    nticks = 0;
    for (int k = 0; k < 3000 && nticks < 3; k++) @(posedge clk);
    chk(last_per, 3);
    chk(tirq, 1'b1);
    rd(OFS_FLAGS_HI, 32'h0000_0002);
    wr(OFS_PCLK_EN, 32'h0000_0000);
    quiet();
    wr(OFS_PCLK_EN, 32'h0000_0080);
    wr(OFS_OSC_SEL, 32'h0000_0000);
    quiet();
    wr(OFS_TMR_CTRL, 32'h0000_0002);
    rd(OFS_COUNT, 32'h0000_0000);
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
